/* File: core/gpc_counter.sv */
// Purpose: Counter mode of a gated pulse counter with two relays.
// Assumes: Host exchanges blocks once per scan, marked by cmd_strobe.
// Notes: Parameter words are fetched one per cycle from the host.
`timescale 1ns/1ps
`default_nettype none
module gpc_counter (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic pulse_in,
   input wire logic gate_in,
   input wire logic mode_select_switch,
   input wire logic gate_polarity_switch,
   input wire logic cmd_strobe,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] out_word1,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] out_word2,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] param_rd_data,
   output logic [gpc_pkg::GPC_WORD_W-1:0] param_rd_addr,
   output logic param_rd_en,
   output logic [gpc_pkg::GPC_WORD_W-1:0] in_word1,
   output logic [gpc_pkg::GPC_WORD_W-1:0] in_word2,
   output logic [gpc_pkg::GPC_WORD_W-1:0] in_word3,
   output logic relay_one,
   output logic relay_two
);
   import gpc_pkg::*;

   // ==========================================================
   // Setup decode
   function automatic logic cfg_bit(input logic [GPC_WORD_W-1:0] w, input int r,
      input int f);
      cfg_bit = w[r*GPC_CFG_STRIDE+f];
   endfunction

   // ==========================================================
   // Input synchronizers
   logic pulse_s1, pulse_s2, pulse_s3;
   logic gate_s1, gate_s2;
   logic gate_act_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pulse_s1 <= 1'b0;
         pulse_s2 <= 1'b0;
         pulse_s3 <= 1'b0;
         gate_s1 <= 1'b0;
         gate_s2 <= 1'b0;
      end else begin
         pulse_s1 <= pulse_in;
         pulse_s2 <= pulse_s1;
         pulse_s3 <= pulse_s2;
         gate_s1 <= gate_in;
         gate_s2 <= gate_s1;
      end
   end
   wire pulse_edge = pulse_s2 & ~pulse_s3;
   wire gate_act = gate_s2 ^ gate_polarity_switch;
   // Edge taken after the switch, so flipping it also starts a run
   // Gate activation edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         // Idle level after reset, no false edge
         gate_act_q <= gate_polarity_switch;
      end else begin
         gate_act_q <= gate_act;
      end
   end
   wire gate_on = gate_act & ~gate_act_q;

   // ==========================================================
   // Command decode
   gpc_state_e state;
   logic fetching;
   logic rd_pending;
   logic [2:0] fetch_idx;
   logic rd_valid;
   logic [2:0] rd_idx;
   logic ran_since_param;
   logic [GPC_WORD_W-1:0] pword [GPC_NPARAM];
   logic [GPC_WORD_W-1:0] setup;
   gpc_count_t trip1, trip2;
   gpc_count_t count;
   logic count_moved;
   logic count_clear;
   logic [4:0] err;

   wire [7:0] cmd_code = out_word1[7:0];
   wire counter_mode = ~mode_select_switch;
   wire cmd_valid = cmd_strobe && (cmd_code != GPC_CMD_NONE);
   wire is_param = cmd_code == GPC_CMD_PARAM;
   wire is_reset = cmd_code == GPC_CMD_RESET;
   wire is_clear = cmd_code == GPC_CMD_CLEAR;
   wire is_known = is_param | is_reset | is_clear;
   wire allowed = is_reset || (is_param && state == GPC_UNPARAM) ||
      (is_clear && state != GPC_RUN);
   wire cmd_busy = cmd_valid && fetching;
   wire cmd_go = cmd_valid && !fetching && counter_mode && is_known && allowed;
   wire do_reset = cmd_go && is_reset;
   wire do_param = cmd_go && is_param;
   wire do_clear = cmd_go && is_clear && !(state == GPC_READY && ran_since_param);

   wire gpc_count_t new_trip1 = gpc_count_t'({pword[1], pword[2]});
   wire gpc_count_t new_trip2 = gpc_count_t'({pword[3], pword[4]});
   wire fetch_last = rd_pending && (fetch_idx == GPC_IDX_LAST);
   wire range_bad = ({pword[1], pword[2]} >= 32'(GPC_TRIP_LIMIT)) ||
      ({pword[3], pword[4]} >= 32'(GPC_TRIP_LIMIT));
   // Last word lands one cycle after the last read
   wire fetch_done = fetching && !rd_pending && !rd_valid && (fetch_idx == GPC_IDX_RST);

   // ==========================================================
   // Parameter fetch
   // Read five words at pointer
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fetching <= 1'b0;
         rd_pending <= 1'b0;
         fetch_idx <= GPC_IDX_RST;
         param_rd_addr <= GPC_WORD_RST;
         param_rd_en <= 1'b0;
      end else if (do_param) begin
         fetching <= 1'b1;
         rd_pending <= 1'b1;
         fetch_idx <= GPC_IDX_RST;
         param_rd_addr <= out_word2;
         param_rd_en <= 1'b1;
      end else if (rd_pending) begin
         rd_pending <= !fetch_last;
         fetch_idx <= fetch_last ? GPC_IDX_RST : 3'(fetch_idx + 3'h1);
         param_rd_addr <= 16'(param_rd_addr + 16'h0001);
         param_rd_en <= !fetch_last;
      end else begin
         // Busy holds until the last answer is stored
         fetching <= rd_valid;
         param_rd_en <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_valid <= 1'b0;
         rd_idx <= GPC_IDX_RST;
      end else begin
         rd_valid <= param_rd_en;
         rd_idx <= fetch_idx;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rd_valid) begin
         pword[rd_idx] <= param_rd_data;
      end
   end

   // ==========================================================
   // State and stored parameters
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= GPC_UNPARAM;
         ran_since_param <= 1'b0;
         setup <= GPC_WORD_RST;
         trip1 <= GPC_COUNT_RST;
         trip2 <= GPC_COUNT_RST;
      end else if (do_reset) begin
         state <= GPC_UNPARAM;
         ran_since_param <= 1'b0;
      end else if (fetch_done && !range_bad) begin
         state <= GPC_READY;
         ran_since_param <= 1'b0;
         setup <= {12'h000, pword[0][3:0]};
         trip1 <= new_trip1;
         trip2 <= new_trip2;
      end else if (state == GPC_READY && gate_on) begin
         state <= GPC_RUN;
         ran_since_param <= 1'b1;
      end else if (state == GPC_RUN && !gate_act) begin
         state <= GPC_READY;
      end
   end

   // ==========================================================
   // Counter
   // Counts while unparameterized
   wire counting = (state == GPC_UNPARAM) || (state == GPC_RUN);
   wire run_start = state == GPC_READY && gate_on && !do_reset;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         count <= GPC_COUNT_RST;
         count_moved <= 1'b0;
         count_clear <= 1'b0;
      end else if (run_start || do_clear) begin
         count <= GPC_COUNT_RST;
         count_moved <= 1'b0;
         count_clear <= 1'b1;
      end else begin
         count <= (counting && pulse_edge) ? gpc_count_t'(count + 24'h000001) : count;
         // Relays see run steps only, never a stale trip
         count_moved <= (state == GPC_RUN) && pulse_edge;
         count_clear <= 1'b0;
      end
   end

   // ==========================================================
   // Errors, updated on each command
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         err <= 5'h00;
      end else if (cmd_valid) begin
         err[0] <= cmd_busy;
         err[1] <= !cmd_busy && is_known && !allowed;
         err[2] <= 1'b0;
         err[3] <= !cmd_busy && !is_known;
         err[4] <= !counter_mode;
      end else if (fetch_done && range_bad) begin
         err[2] <= 1'b1;
      end
   end

   // ==========================================================
   // Relays
   gpc_relay_if rif [2] ();
   wire gpc_count_t trips [2] = '{trip1, trip2};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_relay
         assign rif[gi].enable = state != GPC_UNPARAM;
         assign rif[gi].restart = count_clear;
         assign rif[gi].count_moved = count_moved;
         assign rif[gi].count = count;
         assign rif[gi].trip = trips[gi];
         assign rif[gi].multi = cfg_bit(setup, gi, GPC_CFG_MULTI);
         assign rif[gi].normally_closed = cfg_bit(setup, gi, GPC_CFG_NC);
         gpc_relay u_relay (
            .clk_sys(clk_sys),
            .srst(srst),
            .rif(rif[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Input block
   // Status word assembly
   wire [GPC_WORD_W-1:0] next_status = {fetching, err[1], err[0], err[2], err[3],
      err[4], 5'h00, rif[0].relay, gate_act, 1'b0,
      state == GPC_RUN, state == GPC_READY};
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         in_word1 <= GPC_WORD_RST;
         in_word2 <= GPC_WORD_RST;
         in_word3 <= GPC_WORD_RST;
         relay_one <= 1'b0;
         relay_two <= 1'b0;
      end else begin
         in_word1 <= {next_status[15:6], rif[1].relay, next_status[4:0]};
         in_word2 <= {8'h00, count[23:16]};
         in_word3 <= count[15:0];
         relay_one <= rif[0].relay;
         relay_two <= rif[1].relay;
      end
   end
endmodule
`default_nettype wire

/* File: core/gpc_pkg.sv */
// Purpose: Shared constants and types for the gated pulse counter.
// Assumes: 16-bit data words; status bit n of the word sits at [n].
// Notes: Parameter fetch answers one clock after the read enable.
package gpc_pkg;
   // ==========================================================
   // Widths
   localparam int GPC_COUNT_W = 24;
   localparam int GPC_WORD_W = 16;
   localparam int GPC_NPARAM = 5;

   // ==========================================================
   // Command codes, low byte of the first output word
   localparam logic [7:0] GPC_CMD_NONE = 8'h00;
   localparam logic [7:0] GPC_CMD_PARAM = 8'h01;
   localparam logic [7:0] GPC_CMD_RESET = 8'h02;
   localparam logic [7:0] GPC_CMD_CLEAR = 8'h03;

   // ==========================================================
   // Status word layout
   localparam int GPC_ST_BUSY = 15;
   localparam int GPC_ST_ERR_STATE = 14;
   localparam int GPC_ST_ERR_BUSY = 13;
   localparam int GPC_ST_ERR_RANGE = 12;
   localparam int GPC_ST_ERR_CODE = 11;
   localparam int GPC_ST_ERR_MODE = 10;
   localparam int GPC_ST_RELAY2 = 5;
   localparam int GPC_ST_RELAY1 = 4;
   localparam int GPC_ST_GATE = 3;
   localparam int GPC_ST_RUN = 1;
   localparam int GPC_ST_READY = 0;

   // ==========================================================
   // Relay setup field in the first parameter word
   localparam int GPC_CFG_NC = 0;
   localparam int GPC_CFG_MULTI = 1;
   localparam int GPC_CFG_STRIDE = 2;

   // ==========================================================
   // Limits and reset values
   localparam logic [GPC_COUNT_W-1:0] GPC_TRIP_LIMIT = 24'h7fffff;
   localparam logic [GPC_COUNT_W-1:0] GPC_COUNT_RST = 24'h000000;
   localparam logic [GPC_WORD_W-1:0] GPC_WORD_RST = 16'h0000;
   localparam logic [2:0] GPC_IDX_RST = 3'h0;
   localparam logic [2:0] GPC_IDX_LAST = 3'h4;

   typedef enum logic [1:0] {
      GPC_UNPARAM = 2'b00,
      GPC_READY = 2'b01,
      GPC_RUN = 2'b10
   } gpc_state_e;

   typedef logic [GPC_COUNT_W-1:0] gpc_count_t;
endpackage

/* File: core/gpc_relay.sv */
// Purpose: One relay, tripping at a programmed count.
// Assumes: Count steps by one, so equality catches each point.
// Notes: Relay is off while not enabled.
`timescale 1ns/1ps
`default_nettype none
module gpc_relay (
   input wire logic clk_sys,
   input wire logic srst,
   gpc_relay_if.unit rif
);
   import gpc_pkg::*;
   logic active;
   logic done;
   gpc_count_t mult;
   gpc_count_t quart;
   wire gpc_count_t close_pt = gpc_count_t'(mult + quart);
   wire gpc_count_t quarter_trip = rif.trip >> 2;
   wire hit_single = rif.count_moved && !done && (rif.count == rif.trip);
   wire hit_open = rif.count_moved && !active && (rif.count == mult);
   wire hit_close = rif.count_moved && active && (rif.count == close_pt);

   assign rif.relay = rif.enable & (active ^ rif.normally_closed);

   always_ff @(posedge clk_sys) begin
      if (srst || !rif.enable || rif.restart) begin
         active <= 1'b0;
         done <= 1'b0;
         mult <= rif.trip;
         quart <= quarter_trip;
      end else if (!rif.multi) begin
         if (hit_single) begin
            active <= 1'b1;
            done <= 1'b1;
         end
      end else begin
         if (hit_open) begin
            active <= 1'b1;
         end else if (hit_close) begin
            active <= 1'b0;
            mult <= gpc_count_t'(mult + rif.trip);
            quart <= gpc_count_t'(quart + quarter_trip);
         end
      end
   end
endmodule
`default_nettype wire

/* File: core/gpc_relay_if.sv */
// Purpose: Carrier between the counter core and one relay unit.
// Assumes: Single clock domain.
// Notes: count_moved marks the same cycle the new count shows, on run steps only.
`timescale 1ns/1ps
`default_nettype none
interface gpc_relay_if;
   import gpc_pkg::*;
   logic enable;
   logic restart;
   logic count_moved;
   gpc_count_t count;
   gpc_count_t trip;
   logic multi;
   logic normally_closed;
   logic relay;
   modport ctl (output enable, restart, count_moved, count, trip, multi,
      normally_closed, input relay);
   modport unit (input enable, restart, count_moved, count, trip, multi,
      normally_closed, output relay);
endinterface
`default_nettype wire

/* File: test/gpc_counter_properties.sv */
// Purpose: Port-level properties of the gated pulse counter
// Assumes: One clock, synchronous reset
// Notes: Quiet spans before commands hide status word lag
`timescale 1ns/1ps
`default_nettype none
module gpc_counter_properties (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic gate_in,
   input wire logic mode_select_switch,
   input wire logic cmd_strobe,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] out_word1,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] out_word2,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] param_rd_addr,
   input wire logic param_rd_en,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] in_word1,
   input wire logic relay_one,
   input wire logic relay_two
);
   import gpc_pkg::*;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   // ==========================================
   // Sequences
   sequence s_quiet;
      (!cmd_strobe && $stable(gate_in) && !in_word1[GPC_ST_BUSY]) [*8];
   endsequence
   sequence s_cmd(c, ok);
      cmd_strobe && !mode_select_switch && out_word1[7:0] == c && ok;
   endsequence
   // ==========================================
   // Properties
   AST_PARAM_FETCH: assert property (s_quiet ##1 s_cmd(GPC_CMD_PARAM,
      in_word1[1:0] == 2'b00) |=> param_rd_en [*5] ##1 !param_rd_en)
      else $error("parameter fetch is not five reads");
   AST_FIRST_ADDR: assert property ($rose(param_rd_en) |->
      param_rd_addr == $past(out_word2)) else $error("fetch does not start at pointer");
   AST_NEXT_ADDR: assert property (param_rd_en && $past(param_rd_en) |->
      param_rd_addr == $past(param_rd_addr) + 16'h0001) else $error("fetch address skipped");
   AST_BUSY_FETCH: assert property (param_rd_en |=> in_word1[GPC_ST_BUSY])
      else $error("busy low during fetch");
   AST_RELAY_INERT: assert property ((in_word1[1:0] == 2'b00) [*4] |->
      !relay_one && !relay_two) else $error("relay active while unparameterized");
   AST_CLEAR_RUN: assert property (s_quiet ##1 s_cmd(GPC_CMD_CLEAR,
      in_word1[GPC_ST_RUN]) |-> ##2 in_word1[GPC_ST_ERR_STATE])
      else $error("clear in run without error");
   AST_PARAM_LATE: assert property (s_quiet ##1 s_cmd(GPC_CMD_PARAM,
      in_word1[1:0] != 2'b00) |-> ##2 in_word1[GPC_ST_ERR_STATE])
      else $error("parameterize accepted after parameterized");
   AST_RESET_CLEAN: assert property (s_quiet ##1 s_cmd(GPC_CMD_RESET, 1'b1) |->
      ##2 in_word1[14:10] == 5'h00 ##2 in_word1[1:0] == 2'b00)
      else $error("reset raised error or kept state");
   AST_BAD_CODE: assert property (s_quiet ##1 (cmd_strobe && !mode_select_switch &&
      out_word1[7:0] > GPC_CMD_CLEAR) |-> ##2 in_word1[GPC_ST_ERR_CODE])
      else $error("unknown code without error");
   AST_MODE_ERR: assert property (s_quiet ##1 (cmd_strobe && mode_select_switch &&
      out_word1[7:0] != GPC_CMD_NONE) |-> ##2 in_word1[GPC_ST_ERR_MODE])
      else $error("command in positioning mode without error");
endmodule
bind gpc_counter gpc_counter_properties i_gpc_counter_properties (.clk_sys, .srst, .gate_in,
   .mode_select_switch, .cmd_strobe, .out_word1, .out_word2, .param_rd_addr, .param_rd_en,
   .in_word1, .relay_one, .relay_two);
`default_nettype wire

/* File: test/gpc_host_model.sv */
// Purpose: Controller side, answering parameter reads from its registers
// Assumes: One read latency of one clock
// Notes: Data bus toggles when idle, so stale words never look valid
`timescale 1ns/1ps
`default_nettype none
module gpc_host_model (
   input wire logic clk_sys,
   input wire logic param_rd_en,
   input wire logic [gpc_pkg::GPC_WORD_W-1:0] param_rd_addr,
   output logic [gpc_pkg::GPC_WORD_W-1:0] param_rd_data
);
   import gpc_pkg::*;
   logic [GPC_WORD_W-1:0] mem [0:15];
   initial param_rd_data = GPC_WORD_RST;
   // ==========================================
   // Register answer
   // five words, trips hi then lo
   always @(posedge clk_sys) begin
      if (param_rd_en) begin
         param_rd_data <= mem[param_rd_addr[3:0]];
      end else begin
         param_rd_data <= ~param_rd_data;
      end
   end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: Self-checking bench of the gated pulse counter
// Assumes: Inputs change at the falling edge
// Notes: Expected words are queued, a monitor compares them
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import gpc_pkg::*;
   typedef struct {int sel; logic [15:0] mask; logic [15:0] exp;} gpc_note_s;
   logic clk_sys, srst, pulse_in, gate_in, mode_select_switch, gate_polarity_switch, cmd_strobe;
   logic [15:0] out_word1, out_word2, param_rd_data, param_rd_addr, in_word1, in_word2, in_word3;
   logic param_rd_en, relay_one, relay_two;
   logic [15:0] w;
   int failures = 0;
   int n_tests = 0;
   int seed = 97;
   int k;
   int steps[4] = '{4, 1, 3, 2};
   logic [15:0] cnt[4] = '{16'h0004, 16'h0005, 16'h0008, 16'h000a};
   logic [15:0] rel[4] = '{16'h0000, 16'h0003, 16'h0001, 16'h0003};
   gpc_note_s notes[$];
   gpc_note_s n;
   event look;
   gpc_counter i_gpc_counter (.clk_sys, .srst, .pulse_in, .gate_in, .mode_select_switch,
      .gate_polarity_switch, .cmd_strobe, .out_word1, .out_word2, .param_rd_data,
      .param_rd_addr, .param_rd_en, .in_word1, .in_word2, .in_word3, .relay_one, .relay_two);
   gpc_host_model i_gpc_host_model (.clk_sys, .param_rd_en, .param_rd_addr, .param_rd_data);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ==========================================
   // Tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input int sel);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] out%0d expected %h seen %h", sel, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic expect_word(input int sel, input logic [15:0] mask, input logic [15:0] exp);
      notes.push_back('{sel, mask, exp});
      ->look;
   endtask
   // Quiet span first, then wait out busy under a bound
   task automatic cmd(input logic [7:0] code);
      int i;
      repeat (10) @(negedge clk_sys);
      out_word1 = {8'($random(seed)), code};
      cmd_strobe = 1'b1;
      @(negedge clk_sys);
      cmd_strobe = 1'b0;
      out_word1 = 16'h0000;
      repeat (3) @(negedge clk_sys);
      for (i = 0; i < 20 && in_word1[GPC_ST_BUSY] !== 1'b0; i++) @(negedge clk_sys);
      if (i == 20) failures++;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic pulses(input int cnt_n);
      repeat (cnt_n) begin
         @(negedge clk_sys) pulse_in = 1'b1;
         repeat (3) @(negedge clk_sys);
         pulse_in = 1'b0;
         repeat (3) @(negedge clk_sys);
      end
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic set_gate(input logic v);
      @(negedge clk_sys) gate_in = v;
      repeat (10) @(negedge clk_sys);
   endtask
   // ==========================================
   // Monitor
   initial begin
      forever begin
         @(look);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            w = (n.sel == 1) ? in_word1 : (n.sel == 2) ? in_word2 : (n.sel == 3) ? in_word3
               : {14'h0000, relay_two, relay_one};
            check(w & n.mask, n.exp, n.sel);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      give_verdict();
   end
   // ==========================================
   // Scenarios
   initial begin
      {srst, pulse_in, gate_in, mode_select_switch, gate_polarity_switch, cmd_strobe} = 6'h20;
      out_word1 = 16'h0000;
      out_word2 = 16'h0000;
      i_gpc_host_model.mem[0] = 16'h0000;
      i_gpc_host_model.mem[1] = 16'h007f;
      i_gpc_host_model.mem[2] = 16'hffff;
      i_gpc_host_model.mem[3] = 16'h0000;
      i_gpc_host_model.mem[4] = 16'h0004;
      i_gpc_host_model.mem[8] = {12'($random(seed)), 4'hc};
      i_gpc_host_model.mem[9] = 16'h0000;
      i_gpc_host_model.mem[10] = 16'h0005;
      i_gpc_host_model.mem[11] = 16'h0000;
      i_gpc_host_model.mem[12] = 16'h0004;
      repeat (8) @(negedge clk_sys);
      srst = 1'b0;
      @(negedge clk_sys);
      expect_word(1, 16'hfc03, 16'h0000);
      pulses(3);
      expect_word(3, 16'hffff, 16'h0003);
      expect_word(2, 16'hffff, 16'h0000);
      set_gate(1'b1);
      pulses(1);
      expect_word(3, 16'hffff, 16'h0004);
      expect_word(4, 16'h0003, 16'h0000);
      set_gate(1'b0);
      cmd(GPC_CMD_CLEAR);
      expect_word(3, 16'hffff, 16'h0000);
      pulses(2);
      cmd(8'h04);
      expect_word(1, 16'h0803, 16'h0800);
      cmd(8'hff);
      expect_word(1, 16'h0803, 16'h0800);
      mode_select_switch = 1'b1;
      cmd(GPC_CMD_PARAM);
      expect_word(1, 16'h0403, 16'h0400);
      mode_select_switch = 1'b0;
      cmd(GPC_CMD_PARAM);
      expect_word(1, 16'h1003, 16'h1000);
      out_word2 = 16'h0008;
      cmd(GPC_CMD_PARAM);
      expect_word(1, 16'hfc03, 16'h0001);
      cmd(GPC_CMD_PARAM);
      expect_word(1, 16'h4003, 16'h4001);
      expect_word(3, 16'hffff, 16'h0002);
      cmd(GPC_CMD_CLEAR);
      expect_word(3, 16'hffff, 16'h0000);
      set_gate(1'b1);
      expect_word(1, 16'h003f, 16'h002a);
      for (k = 0; k < 4; k++) begin
         pulses(steps[k]);
         expect_word(3, 16'hffff, cnt[k]);
         expect_word(4, 16'h0003, rel[k]);
         expect_word(1, 16'h0030, rel[k] << 4);
      end
      cmd(GPC_CMD_CLEAR);
      expect_word(1, 16'h4003, 16'h4002);
      set_gate(1'b0);
      pulses(2);
      expect_word(1, 16'h0003, 16'h0001);
      expect_word(3, 16'hffff, 16'h000a);
      cmd(GPC_CMD_CLEAR);
      expect_word(1, 16'hfc00, 16'h0000);
      expect_word(3, 16'hffff, 16'h000a);
      @(negedge clk_sys) gate_polarity_switch = 1'b1;
      repeat (10) @(negedge clk_sys);
      expect_word(1, 16'h0003, 16'h0002);
      expect_word(3, 16'hffff, 16'h0000);
      cmd(GPC_CMD_RESET);
      expect_word(1, 16'hfc03, 16'h0000);
      expect_word(4, 16'h0003, 16'h0000);
      cmd(GPC_CMD_RESET);
      expect_word(1, 16'hfc03, 16'h0000);
      @(negedge clk_sys);
      give_verdict();
   end
endmodule
`default_nettype wire
